// ===== core/lcm_pkg.sv
// Package for the logic cell cluster: register map, field layout, mode codes.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package lcm_pkg;
  // Number of cells chained in one cluster.
  localparam int NCELL = 4;
  localparam int ADR_W = 8;
  // Register byte addresses; cell n config sits at ADR_CFG0 + 4*n.
  localparam logic [7:0] ADR_CFG0 = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  // Cell config word layout.
  localparam int CFG_W = 22;
  localparam int LUT_LSB = 0;
  localparam int LUT_W = 16;
  localparam int CY_LSB = 8;
  localparam int MODE_LSB = 16;
  localparam int SELC_BIT = 18;
  localparam int CASC_LSB = 19;
  localparam int PACK_BIT = 21;
  localparam logic [CFG_W-1:0] CFG_RST = 22'h000000;
  // Mode codes; code 3 is illegal and falls back to normal.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ARITH = 2'h1;
  localparam logic [1:0] MODE_COUNT = 2'h2;
  // Cascade combine codes.
  localparam logic [1:0] CASC_OFF = 2'h0;
  localparam logic [1:0] CASC_AND = 2'h1;
  localparam logic [1:0] CASC_OR = 2'h2;
  // Control word: bit 0 selects the external chain carry start.
  localparam int CTRL_W = 1;
  localparam int CSRC_BIT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;
  // Status word layout.
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_C_LSB = 4;
  localparam int STAT_CO_BIT = 8;
  // Adder tables used by the checks: sum in low byte, carry in high byte.
  localparam logic [15:0] LUT_ADDER = 16'hE896;
endpackage : lcm_pkg

// ===== core/lcm_cell_reg.sv
// One cell register with cluster-wide asynchronous and synchronous controls.
// Assumes all controls are synchronous to clk_i; async ones act on q_o at once.
`timescale 1ns/100ps
`default_nettype none
module lcm_cell_reg (
  input wire logic clk_i,   // Cluster clock.
  input wire logic rst_i,   // Synchronous reset, active high.
  input wire logic ena_i,   // Clock enable.
  input wire logic aclr_i,  // Asynchronous clear.
  input wire logic apre_i,  // Asynchronous preset.
  input wire logic aload_i, // Asynchronous load of ldata_i.
  input wire logic sclr_i,  // Synchronous clear.
  input wire logic sload_i, // Synchronous load of ldata_i.
  input wire logic ldata_i, // Load data.
  input wire logic d_i,     // Normal data input.
  output logic q_o          // Register value seen by the fabric.
);
  logic q_reg;
  logic q_next;
  logic force_act;
  logic force_val;

  // Async controls override the stored value without waiting for a clock,
  // built as a bypass so no flop ever loads a non-constant asynchronously.
  always_comb begin
    force_act = aclr_i | apre_i | aload_i;
    force_val = aclr_i ? 1'b0 : (apre_i ? 1'b1 : ldata_i);
    q_o = force_act ? force_val : q_reg;
  end

  // Sync clear beats sync load, both gated by the clock enable.
  always_comb begin
    q_next = q_reg;
    if (force_act) begin
      q_next = force_val;
    end else if (ena_i) begin
      if (sclr_i) begin
        q_next = 1'b0;
      end else if (sload_i) begin
        q_next = ldata_i;
      end else begin
        q_next = d_i;
      end
    end
  end

  // Storage flop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule : lcm_cell_reg
`default_nettype wire

// ===== core/lcm_cluster.sv
// Cluster of chained logic cells with a classic Wishbone config port.
// Assumes cell inputs and shared controls are synchronous to clk_i.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - each cell runs in exactly one mode: normal, arithmetic or counter.
// - cell inputs are four data lines, own register, carry-in and cascade-in.
// - shared clock, enable, async and sync controls work in every mode.
// - normal mode evaluates one four-input table from the data lines.
// - normal mode chooses third data line or carry-in as a table input.
// - normal mode may combine table with cascade-in to drive cascade-out.
// - normal mode lets the register serve separately from the table.
// - arithmetic mode splits into a result table and a carry table.
// - arithmetic result table uses carry-in, first and second data lines.
// - arithmetic carry table uses the same inputs and drives carry-out.
// - arithmetic mode may still use the cascade chain.
// - arithmetic mode gives registered and combinational results together.
// - counter mode has enable, direction, sync clear and sync load.
module lcm_cluster (
  input wire logic clk_i,                            // Clock, 10 MHz.
  input wire logic rst_i,                            // Sync reset, high.
  input wire logic wb_cyc_i,                         // Bus cycle.
  input wire logic wb_stb_i,                         // Bus strobe.
  input wire logic wb_we_i,                          // Write enable.
  input wire logic [lcm_pkg::ADR_W-1:0] wb_adr_i,    // Byte address.
  input wire logic [3:0] wb_sel_i,                   // Byte lanes.
  input wire logic [31:0] wb_dat_i,                  // Write data.
  output logic [31:0] wb_dat_o,                      // Read data.
  output logic wb_ack_o,                             // Acknowledge.
  input wire logic [lcm_pkg::NCELL-1:0] cell_input_first_i,  // Line 1.
  input wire logic [lcm_pkg::NCELL-1:0] cell_input_second_i, // Line 2.
  input wire logic [lcm_pkg::NCELL-1:0] cell_input_third_i,  // Line 3.
  input wire logic [lcm_pkg::NCELL-1:0] cell_input_fourth_i, // Line 4.
  input wire logic carry_start_i,                    // External chain carry.
  input wire logic cascade_start_i,                  // Chain cascade-in.
  input wire logic ena_i,                            // Shared clock enable.
  input wire logic aclr_i,                           // Shared async clear.
  input wire logic apre_i,                           // Shared async preset.
  input wire logic aload_i,                          // Shared async load.
  input wire logic sclr_i,                           // Shared sync clear.
  input wire logic sload_i,                          // Shared sync load.
  output logic [lcm_pkg::NCELL-1:0] reg_q_o,         // Registered results.
  output logic [lcm_pkg::NCELL-1:0] comb_q_o,        // Combinational results.
  output logic [lcm_pkg::NCELL-1:0] casc_out_o,      // Cascade outputs.
  output logic carry_out_o                           // Last cell carry-out.
);
  localparam int N = lcm_pkg::NCELL;
  localparam int CW = lcm_pkg::CFG_W;

  logic [CW-1:0] cfg_reg [N];
  logic [lcm_pkg::CTRL_W-1:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic req;
  logic [N:0] carry;
  logic [N:0] casc;
  logic [N-1:0] comb_w;
  logic [N-1:0] d_w;
  logic [N-1:0] q_w;
  logic [N-1:0] is_norm;
  logic [N-1:0] is_arith;
  logic [N-1:0] is_cnt;
  logic [N-1:0] lut_w;
  logic [N-1:0] res_w;
  logic [N-1:0] cy_w;
  logic [N-1:0] qr_reg;
  logic [N-1:0] cq_reg;
  logic [N-1:0] co_reg;
  logic cy_reg;

  // A request is served once: ack drops in the cycle after it was given.
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;

  // Chain starts: carry-in of cell 0 is low unless the external source is on.
  always_comb begin
    carry[0] = ctrl_reg[lcm_pkg::CSRC_BIT] ? carry_start_i : 1'b0;
    casc[0] = cascade_start_i;
  end

  // Per-cell datapath; cells link in a fixed order through carry and casc.
  for (genvar i = 0; i < N; i++) begin : g_cell
    logic [1:0] mode;
    logic [1:0] cmode;
    logic [3:0] idx4;
    logic [2:0] idx3;
    logic base;
    logic cen;
    logic up;

    // Seven inputs feed the mode-dependent routing below.
    always_comb begin
      mode = cfg_reg[i][lcm_pkg::MODE_LSB +: 2];
      cmode = cfg_reg[i][lcm_pkg::CASC_LSB +: 2];
      is_arith[i] = (mode == lcm_pkg::MODE_ARITH);
      is_cnt[i] = (mode == lcm_pkg::MODE_COUNT);
      is_norm[i] = ~is_arith[i] & ~is_cnt[i];
      // Third table input is line 3 or the carry-in.
      idx4 = {cell_input_fourth_i[i],
              cfg_reg[i][lcm_pkg::SELC_BIT] ? carry[i] : cell_input_third_i[i],
              cell_input_second_i[i], cell_input_first_i[i]};
      idx3 = {carry[i], cell_input_second_i[i], cell_input_first_i[i]};
      lut_w[i] = cfg_reg[i][lcm_pkg::LUT_LSB + 32'(idx4)];
      res_w[i] = cfg_reg[i][lcm_pkg::LUT_LSB + 32'(idx3)];
      cy_w[i] = cfg_reg[i][lcm_pkg::CY_LSB + 32'(idx3)];
      cen = cell_input_first_i[i];
      up = cell_input_second_i[i];
    end

    // Table result, cascade combine, carry-out and register input.
    always_comb begin
      base = is_arith[i] ? res_w[i] : lut_w[i];
      case (cmode)
        lcm_pkg::CASC_AND: casc[i+1] = base & casc[i];
        lcm_pkg::CASC_OR: casc[i+1] = base | casc[i];
        default: casc[i+1] = base;
      endcase
      if (is_arith[i]) begin
        carry[i+1] = cy_w[i];
        d_w[i] = casc[i+1];
        comb_w[i] = casc[i+1];
      end else if (is_cnt[i]) begin
        // Counter bit toggles when enabled and all lower bits allow it.
        carry[i+1] = cen & carry[i] & (up ? q_w[i] : ~q_w[i]);
        d_w[i] = q_w[i] ^ (cen & carry[i]);
        comb_w[i] = d_w[i];
      end else begin
        carry[i+1] = carry[i];
        // Packed use feeds line 4 straight to the register.
        d_w[i] = cfg_reg[i][lcm_pkg::PACK_BIT] ? cell_input_fourth_i[i]
                                                 : casc[i+1];
        comb_w[i] = casc[i+1];
      end
    end

    lcm_cell_reg u_reg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ena_i(ena_i),
      .aclr_i(aclr_i),
      .apre_i(apre_i),
      .aload_i(aload_i),
      .sclr_i(sclr_i),
      .sload_i(sload_i),
      .ldata_i(cell_input_third_i[i]),
      .d_i(d_w[i]),
      .q_o(q_w[i])
    );
  end

  // Config writes honour byte lanes; they land on the edge that raises ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < N; k++) begin
        cfg_reg[k] <= lcm_pkg::CFG_RST;
      end
      ctrl_reg <= lcm_pkg::CTRL_RST;
    end else if (req && wb_we_i) begin
      for (int k = 0; k < N; k++) begin
        if (wb_adr_i == lcm_pkg::ADR_CFG0 + 8'(4 * k)) begin
          for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
              for (int t = 0; t < 8; t++) begin
                if (b * 8 + t < CW) begin
                  cfg_reg[k][b * 8 + t] <= wb_dat_i[b * 8 + t];
                end
              end
            end
          end
        end
      end
      if (wb_adr_i == lcm_pkg::ADR_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[lcm_pkg::CTRL_W-1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero and are still acknowledged.
  always_comb begin
    rdat_next = 32'h00000000;
    for (int k = 0; k < N; k++) begin
      if (wb_adr_i == lcm_pkg::ADR_CFG0 + 8'(4 * k)) begin
        rdat_next = {{(32 - CW){1'b0}}, cfg_reg[k]};
      end
    end
    if (wb_adr_i == lcm_pkg::ADR_CTRL) begin
      rdat_next = {{(32 - lcm_pkg::CTRL_W){1'b0}}, ctrl_reg};
    end
    if (wb_adr_i == lcm_pkg::ADR_STAT) begin
      rdat_next[lcm_pkg::STAT_Q_LSB +: N] = q_w;
      rdat_next[lcm_pkg::STAT_C_LSB +: N] = comb_w;
      rdat_next[lcm_pkg::STAT_CO_BIT] = carry[N];
    end
  end

  // Bus answer: one cycle after the request is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdat_reg <= wb_we_i ? 32'h00000000 : rdat_next;
      end
    end
  end

  // Outputs are flopped copies, so each shows one cycle after the fabric.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qr_reg <= '0;
      cq_reg <= '0;
      co_reg <= '0;
      cy_reg <= 1'b0;
    end else begin
      qr_reg <= q_w;
      cq_reg <= comb_w;
      co_reg <= casc[N:1];
      cy_reg <= carry[N];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign reg_q_o = qr_reg;
  assign comb_q_o = cq_reg;
  assign casc_out_o = co_reg;
  assign carry_out_o = cy_reg;

  // Checks on cell 0, the shared controls, the chain and the bus.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic quiet;
  logic async_on;
  assign quiet = ~aclr_i & ~apre_i & ~aload_i & ~sclr_i & ~sload_i;
  // A register check one cycle on is moot while an async control forces the value.
  assign async_on = aclr_i | apre_i | aload_i;

  a_one_mode: assert property ($onehot({is_norm[0], is_arith[0], is_cnt[0]}))
    else $error("cell mode not unique");
  a_norm_selc: assert property (
    is_norm[0] && cfg_reg[0][lcm_pkg::SELC_BIT]
    |-> lut_w[0] == cfg_reg[0][{cell_input_fourth_i[0], carry[0],
        cell_input_second_i[0], cell_input_first_i[0]}])
    else $error("carry-in not used as table input");
  a_casc_and: assert property (
    is_norm[0] && cfg_reg[0][lcm_pkg::CASC_LSB +: 2] == lcm_pkg::CASC_AND
    |-> ##1 casc_out_o[0] == $past(lut_w[0] & cascade_start_i))
    else $error("cascade and wrong");
  a_packed_reg: assert property (
    is_norm[0] && cfg_reg[0][lcm_pkg::PACK_BIT] && ena_i && quiet
    |=> async_on || q_w[0] == $past(cell_input_fourth_i[0]))
    else $error("packed register not loaded");
  a_arith_sum: assert property (
    is_arith[0] && cfg_reg[0][15:0] == lcm_pkg::LUT_ADDER
    && cfg_reg[0][lcm_pkg::CASC_LSB +: 2] == lcm_pkg::CASC_OFF
    |-> comb_w[0] == (carry[0] ^ cell_input_first_i[0] ^ cell_input_second_i[0]))
    else $error("adder sum wrong");
  a_arith_carry: assert property (
    is_arith[0] && cfg_reg[0][15:0] == lcm_pkg::LUT_ADDER
    |-> carry[1] == ((carry[0] & cell_input_first_i[0])
        | (carry[0] & cell_input_second_i[0])
        | (cell_input_first_i[0] & cell_input_second_i[0])))
    else $error("adder carry wrong");
  a_casc_arith: assert property (
    is_arith[0] && cfg_reg[0][15:0] == lcm_pkg::LUT_ADDER
    && cfg_reg[0][lcm_pkg::CASC_LSB +: 2] == lcm_pkg::CASC_OR
    |-> casc[1] == ((carry[0] ^ cell_input_first_i[0] ^ cell_input_second_i[0])
        | cascade_start_i))
    else $error("cascade beside carry wrong");
  a_both_forms: assert property (
    is_arith[0] && ena_i && quiet
    |=> (async_on || q_w[0] == $past(comb_w[0])) && comb_q_o[0] == $past(comb_w[0]))
    else $error("registered and comb forms differ");
  a_cnt_toggle: assert property (
    is_cnt[0] && ena_i && quiet && carry[0] && cell_input_first_i[0]
    |=> async_on || q_w[0] != $past(q_w[0]))
    else $error("counter bit did not toggle");
  a_cnt_carry: assert property (
    is_cnt[0] |-> carry[1] == (cell_input_first_i[0] & carry[0]
        & (cell_input_second_i[0] ? q_w[0] : ~q_w[0])))
    else $error("counter carry wrong");
  a_aclr_first: assert property (aclr_i |-> q_w == '0 ##1 reg_q_o == '0)
    else $error("async clear not immediate");
  a_apre_first: assert property (apre_i && !aclr_i |-> q_w == '1)
    else $error("async preset not immediate");
  a_aload_first: assert property (
    aload_i && !aclr_i && !apre_i |-> q_w == cell_input_third_i)
    else $error("async load not immediate");
  a_sync_clr: assert property (
    ena_i && sclr_i && !async_on |=> async_on || q_w == '0)
    else $error("sync clear ignored");
  a_sync_load: assert property (
    ena_i && sload_i && !sclr_i && !async_on
    |=> async_on || q_w == $past(cell_input_third_i))
    else $error("sync load ignored");
  a_chain_low: assert property (!ctrl_reg[lcm_pkg::CSRC_BIT] |-> carry[0] == 1'b0)
    else $error("chain start not low");
  a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !ack_reg |=> ack_reg ##1 !ack_reg)
    else $error("ack timing wrong");

  c_arith: cover property (is_arith[0] && carry[1]);
  c_count: cover property (is_cnt[0] && ena_i && carry[1]);
  c_casc: cover property (is_norm[0] && casc[N]);
  c_aload: cover property (aload_i && !aclr_i && !apre_i);
  c_packed: cover property (is_norm[0] && cfg_reg[0][lcm_pkg::PACK_BIT] && ena_i);
endmodule : lcm_cluster
`default_nettype wire

// ===== tb/lcm_fabric_model.sv
// Model of the local routing and the neighbouring cells that feed the cluster.
// Assumes the bench sets ln_i and sh_i by non-blocking assignment at clk_i.
`timescale 1ns/100ps
`default_nettype none
module lcm_fabric_model (
  input wire logic clk_i,       // Cluster clock.
  input wire logic rst_i,       // Sync reset, high.
  input wire logic [15:0] ln_i, // Lines four..one, one nibble each.
  input wire logic [7:0] sh_i,  // Carry, cascade, ena, aclr, apre, aload, sclr, sload.
  output logic [3:0] l1_o,      // First data lines.
  output logic [3:0] l2_o,      // Second data lines.
  output logic [3:0] l3_o,      // Third data lines.
  output logic [3:0] l4_o,      // Fourth data lines.
  output logic cs_o,            // Chain carry start.
  output logic cc_o,            // Chain cascade start.
  output logic ena_o,           // Shared clock enable.
  output logic aclr_o,          // Shared async clear.
  output logic apre_o,          // Shared async preset.
  output logic aload_o,         // Shared async load.
  output logic sclr_o,          // Shared sync clear.
  output logic sload_o          // Shared sync load.
);
  // Routing is registered, so every line changes just after an edge, never mid-cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {l4_o, l3_o, l2_o, l1_o} <= 16'h0000;
      {cs_o, cc_o, ena_o, aclr_o, apre_o, aload_o, sclr_o, sload_o} <= 8'h00;
    end else begin
      {l4_o, l3_o, l2_o, l1_o} <= ln_i;
      {cs_o, cc_o, ena_o, aclr_o, apre_o, aload_o, sclr_o, sload_o} <= sh_i;
    end
  end
endmodule : lcm_fabric_model
`default_nettype wire

// ===== tb/lcm_cluster_tb.sv
// Self-checking bench for the logic cell cluster, fed through the fabric model.
// Assumes the lcm_pkg register map and a one-cycle Wishbone answer.
`timescale 1ns/100ps
`default_nettype none
module lcm_cluster_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, cout, cs, cc, ena, aclr, apre, aload, sclr, sload;
  logic [7:0] adr, sh;
  logic [3:0] sel, l1, l2, l3, l4, rq, cq, co;
  logic [31:0] wdat, rdat;
  logic [15:0] ln;
  logic [12:0] mask, val;
  logic [31:0] rd_q[$];
  logic [25:0] fab_q[$];
  int fails, checked;

  lcm_cluster i_lcm_cluster (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cell_input_first_i(l1), .cell_input_second_i(l2),
    .cell_input_third_i(l3), .cell_input_fourth_i(l4), .carry_start_i(cs),
    .cascade_start_i(cc), .ena_i(ena), .aclr_i(aclr), .apre_i(apre), .aload_i(aload),
    .sclr_i(sclr), .sload_i(sload), .reg_q_o(rq), .comb_q_o(cq), .casc_out_o(co),
    .carry_out_o(cout));

  lcm_fabric_model i_lcm_fabric_model (.clk_i(clk_i), .rst_i(rst_i), .ln_i(ln), .sh_i(sh),
    .l1_o(l1), .l2_o(l2), .l3_o(l3), .l4_o(l4), .cs_o(cs), .cc_o(cc), .ena_o(ena),
    .aclr_o(aclr), .apre_o(apre), .aload_o(aload), .sclr_o(sclr), .sload_o(sload));

  // Free-running 10 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    // Expectations still queued mean an answer never came.
    fails += rd_q.size() + fab_q.size();
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // One classic cycle; the request stands until ack, only the watchdog ends the wait.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    {cyc, stb} <= 2'b00;
  endtask : wb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task cfg(input logic [31:0] c);
    for (int i = 0; i < 4; i++) wb(1'b1, lcm_pkg::ADR_CFG0 + 8'(4 * i), c);
  endtask : cfg

  // Four edges cover the routing flop, the cell register and the output flop.
  task expect_fab(input logic [12:0] m, input logic [12:0] v);
    repeat (4) @(posedge clk_i);
    fab_q.push_back({m, v});
  endtask : expect_fab

  // Read data is taken at the edge where ack is sampled high.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) check(rdat, rd_q.pop_front());
  end

  // Fabric outputs are judged mid-cycle, when they have settled.
  always @(negedge clk_i) begin
    if (fab_q.size() > 0) begin
      {mask, val} = fab_q.pop_front();
      check({19'h0, {cout, co, cq, rq} & mask}, {19'h0, val & mask});
    end
  end

  // Stimulus: registers, adder chain, normal tables, register controls, counter.
  initial begin
    logic [31:0] r;
    logic [3:0] a, b, s, t, q;
    logic c, acc;
    logic [15:0] tbl;
    int n;
    {cyc, stb, we, adr, sel, wdat, ln, sh} = '0;
    fails = 0;
    checked = 0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(88));
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0);
    r = $urandom;
    wb(1'b1, lcm_pkg::ADR_CFG0, r);
    rd(lcm_pkg::ADR_CFG0, r & 32'h003FFFFF);
    wb(1'b1, lcm_pkg::ADR_CTRL, 32'hFFFFFFFF);
    rd(lcm_pkg::ADR_CTRL, 32'h1);
    cfg({14'h0, lcm_pkg::MODE_ARITH, lcm_pkg::LUT_ADDER});
    for (int k = 0; k < 8; k++) begin
      {a, b, c} = 9'($urandom);
      ln <= {8'h0, b, a};
      sh <= {c, 7'h20};
      for (int i = 0; i < 4; i++) begin
        s[i] = a[i] ^ b[i] ^ c;
        c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
      end
      expect_fab(13'h10FF, {c, 4'h0, s, s});
    end
    wb(1'b1, lcm_pkg::ADR_STAT, 32'hFFFFFFFF);
    rd(lcm_pkg::ADR_STAT, {23'h0, c, s, s});
    // Adder with the cascade chain on as well: OR cascade beside the carry chain.
    cfg({11'h0, lcm_pkg::CASC_OR, 1'b0, lcm_pkg::MODE_ARITH, lcm_pkg::LUT_ADDER});
    for (int k = 0; k < 4; k++) begin
      {a, b, c, acc} = 10'($urandom);
      ln <= {8'h0, b, a};
      sh <= {c, acc, 6'h20};
      for (int i = 0; i < 4; i++) begin
        s[i] = a[i] ^ b[i] ^ c;
        c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
        acc = s[i] | acc;
        t[i] = acc;
      end
      expect_fab(13'h1FFF, {c, t, t, t});
    end
    for (int k = 0; k < 6; k++) begin
      tbl = 16'($urandom);
      r = $urandom;
      cfg({11'h0, 2'(k % 3), 1'(k / 3), 2'b00, tbl});
      ln <= r[15:0];
      sh <= {r[17:16], 6'h20};
      acc = r[16];
      for (int i = 0; i < 4; i++) begin
        s[i] = tbl[{r[12 + i], (k > 2 ? r[17] : r[8 + i]), r[4 + i], r[i]}];
        acc = (k % 3 == 1) ? (s[i] & acc) : (s[i] | acc);
        t[i] = acc;
      end
      expect_fab((k % 3 != 0) ? 13'h1F00 : 13'h10F0, {r[17], t, s, 4'h0});
    end
    // Packed register: the table stays zero while line four feeds the register.
    cfg(32'h00200000);
    for (int k = 0; k < 16; k++) begin
      r = $urandom;
      if (k == 0) r[21:16] = 6'h10;
      ln <= r[15:0];
      sh <= {2'b00, r[21:16]};
      a = r[11:8];
      if (r[20]) q = 4'h0;
      else if (r[19]) q = 4'hF;
      else if (r[18]) q = a;
      else if (r[21]) q = r[17] ? 4'h0 : (r[16] ? a : r[15:12]);
      expect_fab(13'h00FF, {9'h0, q});
    end
    cfg(32'h00020000);
    ln <= 16'h0;
    sh <= 8'hA2;
    expect_fab(13'h000F, 13'h0);
    q = 4'h0;
    sh <= 8'hA0;
    for (int k = 1; k >= 0; k--) begin
      n = 1 + $urandom % 12;
      ln <= (k == 1) ? 16'h00FF : 16'h000F;
      repeat (n) @(posedge clk_i);
      ln <= 16'h0;
      q = (k == 1) ? q + 4'(n) : q - 4'(n);
      expect_fab(13'h000F, {9'h0, q});
    end
    r = $urandom;
    ln <= {4'h0, r[3:0], 8'h0};
    sh <= 8'hA1;
    expect_fab(13'h000F, {9'h0, r[3:0]});
    repeat (2) @(posedge clk_i);
    tally_and_finish;
  end

  // Watchdog: the tests need well under 2,000 cycles; 20,000 means a hang.
  initial begin
    #2000000;
    fails++;
    tally_and_finish;
  end
endmodule : lcm_cluster_tb
`default_nettype wire
